// ===== logic/lpw_pkg.sv
// Purpose: shared constants and types of the eight-channel led pwm block
// Assumes: 200 MHz system clock
// Notes: register indices are plain offsets on the register port
package lpw_pkg;
  // timing
  localparam int CLK_HZ = 200_000_000;
  localparam int OSC_HZ = 25_000_000;
  localparam int OSC_DIV = CLK_HZ / OSC_HZ;
  localparam int PWM_STEPS = 256;
  localparam int DIM_HZ = 190;
  localparam int BLINK_MAX_HZ = 24;
  localparam int DIM_STEP_TICKS = OSC_HZ / (DIM_HZ * PWM_STEPS);
  localparam int BLINK_STEP_TICKS = OSC_HZ / (BLINK_MAX_HZ * PWM_STEPS);
  // sizes
  localparam int NUM_LEDS = 8;
  localparam int NUM_REGS = 18;
  localparam int AW = 5;
  // register indices
  localparam logic [AW-1:0] REG_MODE_A = 5'h00;
  localparam logic [AW-1:0] REG_MODE_B = 5'h01;
  localparam logic [AW-1:0] REG_BRIGHT0 = 5'h02;
  localparam logic [AW-1:0] REG_GRP_DUTY = 5'h0a;
  localparam logic [AW-1:0] REG_GRP_FREQ = 5'h0b;
  localparam logic [AW-1:0] REG_STATE0 = 5'h0c;
  localparam logic [AW-1:0] REG_SUB1 = 5'h0e;
  localparam logic [AW-1:0] REG_ALL = 5'h11;
  localparam logic [AW-1:0] REG_STATUS = 5'h12;
  // fields
  localparam int MA_ALL_EN = 0;
  localparam int MA_SUB1_EN = 1;
  localparam int MB_GATE = 0;
  localparam int MB_TOTEM = 2;
  localparam int MB_ACK_UPD = 3;
  localparam int MB_BLINK = 5;
  localparam logic [1:0] GATE_LOW = 2'h0;
  localparam logic [1:0] GATE_HIGH = 2'h1;
  localparam int PIN_SCL = 0;
  localparam int PIN_SDA = 1;
  localparam int PIN_GATE = 2;
  localparam int PIN_ADDR = 3;
  localparam int NUM_PINS = 10;
  localparam logic [7:0] SOFT_RESET_BYTE = 8'h06;
  // led output states
  typedef enum logic [1:0] {LS_OFF, LS_ON, LS_IND, LS_GRP} lpw_led_st_t;
  // link receiver states
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK} lpw_link_st_t;

  // power-on value of each register
  function automatic logic [7:0] lpw_reg_rst(input int i);
    case (i)
      REG_MODE_A: lpw_reg_rst = 8'h01;
      REG_MODE_B: lpw_reg_rst = 8'h06;
      REG_GRP_DUTY: lpw_reg_rst = 8'hff;
      REG_SUB1: lpw_reg_rst = 8'he2;
      REG_SUB1 + 1: lpw_reg_rst = 8'he4;
      REG_SUB1 + 2: lpw_reg_rst = 8'he8;
      REG_ALL: lpw_reg_rst = 8'he0;
      default: lpw_reg_rst = 8'h00;
    endcase
  endfunction
endpackage

// ===== logic/lpw_led_pwm.sv
// Purpose: eight led pwm channels with group dim/blink, driven over a two-wire slave link
// Assumes: link pins and gate pin are asynchronous; register port is on clk
// Notes: the gate pin passes a synchroniser, so forcing lags the pin by a few cycles
// What this block does
// - each led has an 8-bit, 256-step pwm near 97 kHz
// - shared group pwm dims at 190 Hz or blinks at programmable slow rate
// - each led is off, on, individual pwm, or individual and group
// - software picks open-drain or totem-pole outputs, totem-pole after reset
// - link writes apply at each acknowledge or all at stop, stop by default
// - gate pin high forces outputs to 0, 1 or released, released by default
// - soft reset call resets everything except the pin synchronisers as at power-on, leds off
// - all-call and three sub-call addresses, each software enabled
// - own address comes from seven address pins
// - all pwm timing from a 25 MHz tick
// - brightness resets to off, group duty resets to maximum
// - last address bit one means read, zero means write
// - first written byte after address is the control byte
// - soft reset call acknowledged only with write direction
`timescale 1ns/1ps
module lpw_led_pwm
  import lpw_pkg::*;
#(
  parameter int BLINK_TICKS = BLINK_STEP_TICKS
)
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register port
  input wire logic [AW-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [7:0] regRdData,
  // two-wire link
  input wire logic sclPin,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOeN,
  // address and gate pins, hw_addr_bit0 is bit 0
  input wire logic [6:0] hwAddrPins,
  input wire logic outGateN,
  // led pins
  output logic [NUM_LEDS-1:0] ledOut,
  output logic [NUM_LEDS-1:0] ledOeN
);

  logic swReset_reg;
  logic rstAct;
  logic [NUM_PINS-1:0] sync1_reg, sync2_reg, sync3_reg, pinQ_reg, pinQd_reg;
  logic [7:0] regs_reg [NUM_REGS];
  logic [7:0] pend_reg [NUM_REGS];
  logic [NUM_REGS-1:0] dirty_reg;
  logic [7:0] rdData_reg;
  logic [2:0] oscCnt_reg;
  logic oscTick_reg;
  logic [7:0] pwmCnt_reg, grpCnt_reg;
  logic [20:0] grpPre_reg, grpLim;
  lpw_link_st_t st_reg;
  logic [7:0] shift_reg, txShift_reg;
  logic [3:0] bitCnt_reg;
  logic [1:0] byteIdx_reg;
  logic [AW-1:0] ptr_reg;
  logic readMode_reg, nack_reg, swPend_reg, sdaOeN_reg, sdaOut_reg;
  logic [NUM_LEDS-1:0] ledOut_reg, ledOeN_reg, ledOut_next, ledOeN_next;

  // soft reset acts like the reset pin everywhere except in the pin synchronisers
  assign rstAct = !resetn || swReset_reg;

  // register read including the live status word
  function automatic logic [7:0] readReg(input logic [AW-1:0] a);
    if (a == REG_STATUS)
      readReg = {pinQ_reg[PIN_GATE], pinQ_reg[PIN_ADDR +: 7]};
    else if (a < AW'(NUM_REGS))
      readReg = regs_reg[a];
    else
      readReg = 8'h00;
  endfunction

  // pointer steps through the map and wraps after the status word
  function automatic logic [AW-1:0] nextPtr(input logic [AW-1:0] p);
    nextPtr = (p == REG_STATUS) ? '0 : p + AW'(1);
  endfunction

  // idle pin levels: link lines high, gate and address low, so no false start or forced leds after reset
  localparam logic [NUM_PINS-1:0] PIN_IDLE = NUM_PINS'((1 << PIN_SCL) | (1 << PIN_SDA));

  // three-flop synchronisers; a level counts once stages two and three agree
  always_ff @(posedge clk)
    if (!resetn)
    begin
      sync1_reg <= PIN_IDLE;
      sync2_reg <= PIN_IDLE;
      sync3_reg <= PIN_IDLE;
      pinQ_reg <= PIN_IDLE;
      pinQd_reg <= PIN_IDLE;
    end
    else
    begin
      sync1_reg <= {hwAddrPins, outGateN, sdaIn, sclPin};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      pinQ_reg <= (sync2_reg & sync3_reg) | (pinQ_reg & (sync2_reg ^ sync3_reg));
      pinQd_reg <= pinQ_reg;
    end

  // link events from filtered levels
  logic sclRise, sclFall, startEv, stopEv, sdaQ;
  assign sdaQ = pinQ_reg[PIN_SDA];
  assign sclRise = pinQ_reg[PIN_SCL] && !pinQd_reg[PIN_SCL];
  assign sclFall = !pinQ_reg[PIN_SCL] && pinQd_reg[PIN_SCL];
  assign startEv = pinQ_reg[PIN_SCL] && pinQd_reg[PIN_SCL] && pinQd_reg[PIN_SDA] && !sdaQ;
  assign stopEv = pinQ_reg[PIN_SCL] && pinQd_reg[PIN_SCL] && !pinQd_reg[PIN_SDA] && sdaQ;

  // address decode of the first byte
  logic isSoft, addrHit, byteDone, dataWr, ackUpd;
  logic [7:0] rdByte;
  always_comb
  begin
    isSoft = (shift_reg == SOFT_RESET_BYTE);
    addrHit = isSoft || (shift_reg[7:1] == pinQ_reg[PIN_ADDR +: 7]);
    if (regs_reg[REG_MODE_A][MA_ALL_EN] && shift_reg[7:1] == regs_reg[REG_ALL][7:1])
      addrHit = 1'b1;
    for (int k = 0; k < 3; k++)
      if (regs_reg[REG_MODE_A][MA_SUB1_EN + k] && shift_reg[7:1] == regs_reg[REG_SUB1 + k][7:1])
        addrHit = 1'b1;
  end
  assign byteDone = (st_reg == ST_RX) && sclFall && (bitCnt_reg == 4'h8);
  assign dataWr = byteDone && (byteIdx_reg == 2'h2) && !readMode_reg;
  assign ackUpd = regs_reg[REG_MODE_B][MB_ACK_UPD];
  // a process, not an assign, so changes of the registers behind the pointer are seen
  always_comb rdByte = readReg(ptr_reg);

  // link slave: receive, acknowledge, transmit
  always_ff @(posedge clk)
    if (rstAct)
    begin
      st_reg <= ST_IDLE;
      shift_reg <= 8'h00;
      txShift_reg <= 8'h00;
      bitCnt_reg <= 4'h0;
      byteIdx_reg <= 2'h0;
      ptr_reg <= '0;
      readMode_reg <= 1'b0;
      nack_reg <= 1'b0;
      swPend_reg <= 1'b0;
      sdaOeN_reg <= 1'b1;
    end
    else if (startEv)
    begin
      st_reg <= ST_RX;
      bitCnt_reg <= 4'h0;
      byteIdx_reg <= 2'h0;
      swPend_reg <= 1'b0;
      sdaOeN_reg <= 1'b1;
    end
    else if (stopEv)
    begin
      st_reg <= ST_IDLE;
      sdaOeN_reg <= 1'b1;
    end
    else
      case (st_reg)
        ST_RX:
          if (sclRise && bitCnt_reg != 4'h8)
          begin
            shift_reg <= {shift_reg[6:0], sdaQ};
            bitCnt_reg <= bitCnt_reg + 4'h1;
          end
          else if (byteDone)
          begin
            bitCnt_reg <= 4'h0;
            if (byteIdx_reg != 2'h2)
              byteIdx_reg <= byteIdx_reg + 2'h1;
            if (byteIdx_reg == 2'h0)
            begin
              readMode_reg <= shift_reg[0];
              swPend_reg <= isSoft;
              st_reg <= addrHit ? ST_ACK : ST_IDLE;
              sdaOeN_reg <= !addrHit;
            end
            else
            begin
              st_reg <= ST_ACK;
              sdaOeN_reg <= 1'b0;
              ptr_reg <= (byteIdx_reg == 2'h1) ? shift_reg[AW-1:0] : nextPtr(ptr_reg);
            end
          end
        ST_ACK, ST_MACK:
          if (sclRise)
            nack_reg <= sdaQ;
          else if (sclFall && (st_reg == ST_ACK || !nack_reg) && readMode_reg)
          begin
            txShift_reg <= rdByte;
            sdaOeN_reg <= rdByte[7];
            ptr_reg <= nextPtr(ptr_reg);
            st_reg <= ST_TX;
          end
          else if (sclFall)
          begin
            sdaOeN_reg <= 1'b1;
            st_reg <= readMode_reg ? ST_IDLE : ST_RX;
          end
        ST_TX:
          if (sclFall && bitCnt_reg == 4'h7)
          begin
            sdaOeN_reg <= 1'b1;
            bitCnt_reg <= 4'h0;
            st_reg <= ST_MACK;
          end
          else if (sclFall)
          begin
            sdaOeN_reg <= txShift_reg[6];
            txShift_reg <= {txShift_reg[6:0], 1'b0};
            bitCnt_reg <= bitCnt_reg + 4'h1;
          end
        default: ;
      endcase

  // soft reset pulse at the stop that ends an acknowledged call
  always_ff @(posedge clk)
    if (!resetn)
      swReset_reg <= 1'b0;
    else
      swReset_reg <= stopEv && swPend_reg && !swReset_reg;

  // staged link writes, applied together at stop
  always_ff @(posedge clk)
    if (rstAct)
      dirty_reg <= '0;
    else
      for (int i = 0; i < NUM_REGS; i++)
        if (dataWr && !ackUpd && ptr_reg == AW'(i))
        begin
          pend_reg[i] <= shift_reg;
          dirty_reg[i] <= 1'b1;
        end
        else if (stopEv)
          dirty_reg[i] <= 1'b0;

  // live registers; the register port wins over link traffic
  always_ff @(posedge clk)
    for (int i = 0; i < NUM_REGS; i++)
      if (rstAct)
        regs_reg[i] <= lpw_reg_rst(i);
      else if (regWrStb && regAddr == AW'(i))
        regs_reg[i] <= regWrData;
      else if (stopEv && dirty_reg[i])
        regs_reg[i] <= pend_reg[i];
      else if (dataWr && ackUpd && ptr_reg == AW'(i))
        regs_reg[i] <= shift_reg;

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk)
    if (rstAct)
      rdData_reg <= 8'h00;
    else
      rdData_reg <= regRdStb ? readReg(regAddr) : 8'h00;

  // 25 MHz tick from the system clock
  always_ff @(posedge clk)
    if (rstAct)
    begin
      oscCnt_reg <= 3'h0;
      oscTick_reg <= 1'b0;
    end
    else
    begin
      oscCnt_reg <= (oscCnt_reg == 3'(OSC_DIV - 1)) ? 3'h0 : oscCnt_reg + 3'h1;
      oscTick_reg <= (oscCnt_reg == 3'(OSC_DIV - 1));
    end

  // group step length: fixed for dimming, scaled by the frequency register for blinking
  assign grpLim = regs_reg[REG_MODE_B][MB_BLINK]
    ? 21'((32'(regs_reg[REG_GRP_FREQ]) + 32'd1) * BLINK_TICKS - 1)
    : 21'(DIM_STEP_TICKS - 1);

  // free-running counters of both modulators
  always_ff @(posedge clk)
    if (rstAct)
    begin
      pwmCnt_reg <= 8'h00;
      grpCnt_reg <= 8'h00;
      grpPre_reg <= '0;
    end
    else if (oscTick_reg)
    begin
      pwmCnt_reg <= pwmCnt_reg + 8'h01;
      grpPre_reg <= (grpPre_reg >= grpLim) ? '0 : grpPre_reg + 21'h1;
      if (grpPre_reg >= grpLim)
        grpCnt_reg <= grpCnt_reg + 8'h01;
    end

  // per-led output selection
  logic grpOn, gateOff;
  assign grpOn = grpCnt_reg < regs_reg[REG_GRP_DUTY];
  assign gateOff = pinQ_reg[PIN_GATE];
  for (genvar g = 0; g < NUM_LEDS; g++)
  begin : g_led
    logic [1:0] ls;
    logic indOn, act;
    assign ls = regs_reg[REG_STATE0 + g / 4][2 * (g % 4) +: 2];
    assign indOn = pwmCnt_reg < regs_reg[REG_BRIGHT0 + g];
    always_comb
    begin
      case (lpw_led_st_t'(ls))
        LS_OFF: act = 1'b0;
        LS_ON: act = 1'b1;
        LS_IND: act = indOn;
        default: act = indOn && grpOn;
      endcase
      if (gateOff)
      begin
        ledOut_next[g] = regs_reg[REG_MODE_B][MB_GATE +: 2] == GATE_HIGH;
        ledOeN_next[g] = regs_reg[REG_MODE_B][MB_GATE + 1];
      end
      else if (regs_reg[REG_MODE_B][MB_TOTEM])
      begin
        ledOut_next[g] = !act;
        ledOeN_next[g] = 1'b0;
      end
      else
      begin
        ledOut_next[g] = 1'b0;
        ledOeN_next[g] = !act;
      end
    end
  end

  // pin flops; reset drives all leds high, i.e. off
  always_ff @(posedge clk)
    if (rstAct)
    begin
      ledOut_reg <= '1;
      ledOeN_reg <= '0;
      sdaOut_reg <= 1'b0;
    end
    else
    begin
      ledOut_reg <= ledOut_next;
      ledOeN_reg <= ledOeN_next;
      sdaOut_reg <= 1'b0;
    end

  assign regRdData = rdData_reg;
  assign sdaOut = sdaOut_reg;
  assign sdaOeN = sdaOeN_reg;
  assign ledOut = ledOut_reg;
  assign ledOeN = ledOeN_reg;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rstAct);
  logic [1:0] ls0;
  logic [7:0] modeB;
  assign ls0 = regs_reg[REG_STATE0][1:0];
  assign modeB = regs_reg[REG_MODE_B];

  property p_tick;
    oscTick_reg |=> !oscTick_reg [*7] ##1 oscTick_reg;
  endproperty
  a_tick: assert property (p_tick) else $error("tick spacing wrong");
  property p_pwm;
    oscTick_reg |=> pwmCnt_reg == $past(pwmCnt_reg) + 8'h01;
  endproperty
  a_pwm: assert property (p_pwm) else $error("pwm counter stalled");
  property p_zero;
    (ls0 == LS_IND && regs_reg[REG_BRIGHT0] == 8'h00 && !gateOff && modeB[MB_TOTEM]) |=> ledOut_reg[0];
  endproperty
  a_zero: assert property (p_zero) else $error("zero brightness lit led");
  property p_on;
    (ls0 == LS_ON && !gateOff && modeB[MB_TOTEM]) |=> !ledOut_reg[0] && !ledOeN_reg[0];
  endproperty
  a_on: assert property (p_on) else $error("on state not lit");
  property p_odrain;
    (!gateOff && !modeB[MB_TOTEM]) |=> ledOut_reg == '0;
  endproperty
  a_odrain: assert property (p_odrain) else $error("open drain drove high");
  property p_gate;
    (gateOff && modeB[MB_GATE + 1]) |=> ledOeN_reg == '1;
  endproperty
  a_gate: assert property (p_gate) else $error("gate did not release");
  property p_soft_rd;
    (byteDone && byteIdx_reg == 2'h0 && shift_reg == 8'h07 && pinQ_reg[PIN_ADDR +: 7] != 7'h03) |=> sdaOeN_reg;
  endproperty
  a_soft_rd: assert property (p_soft_rd) else $error("read soft reset acked");
  property p_defaults;
    $rose(resetn) |-> regs_reg[REG_GRP_DUTY] == 8'hff && regs_reg[REG_BRIGHT0] == 8'h00;
  endproperty
  a_defaults: assert property (p_defaults) else $error("bad reset values");
  property p_soft;
    (stopEv && swPend_reg) |=> swReset_reg;
  endproperty
  a_soft: assert property (disable iff (!resetn) p_soft) else $error("soft reset missed");
endmodule // lpw_led_pwm

// ===== verif/lpw_i2c_master.sv
// Purpose: behavioural two-wire bus master for the led pwm bench
// Assumes: sda has a pull-up, scl idles high between frames
// Notes: bit period 125 ns, tasks are called by the testbench
`timescale 1ns/1ps
module lpw_i2c_master
(
  // link lines
  output logic scl,
  output logic sdaDrv,
  input wire logic sdaWire
);
  localparam realtime Q = 31.25;
  // idle bus, both lines released
  initial
  begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end
  // sda only moves while scl is low, so no false start or stop
  task automatic bitx(input logic b, output logic r);
    sdaDrv = b;
    #Q scl = 1'b1;
    #Q r = sdaWire;
    #Q scl = 1'b0;
    #Q;
  endtask
  task automatic start();
    sdaDrv = 1'b1;
    #Q scl = 1'b1;
    #Q sdaDrv = 1'b0;
    #Q scl = 1'b0;
    #Q;
  endtask
  task automatic stop();
    sdaDrv = 1'b0;
    #Q scl = 1'b1;
    #Q sdaDrv = 1'b1;
    #Q;
  endtask
  // msb first, then release sda for the ack slot
  task automatic wrByte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(b[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask
  task automatic rdByte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(1'b1, d[i]);
    bitx(nack, r);
  endtask
  // direction rides in the last address bit
  task automatic sendAddr(input logic [6:0] a, input logic rd, output logic ack);
    start();
    wrByte({a, rd}, ack);
  endtask
endmodule // lpw_i2c_master

// ===== verif/testbench.sv
// Purpose: self-checking bench for the eight-channel led pwm block
// Assumes: bus master model drives the link pins
// Notes: BLINK_TICKS shortened, blink timing itself is not measured
`timescale 1ns/1ps
module testbench;
  import lpw_pkg::*;
  typedef struct {logic w; logic [AW-1:0] a; logic [7:0] d; logic [7:0] e;} lpw_row_t;
  // design ports
  logic clk, resetn, regWrStb, regRdStb, outGateN;
  logic [AW-1:0] regAddr;
  logic [7:0] regWrData, regRdData, rd, lnk;
  logic sclPin, sdaDrv, sdaOut, sdaOeN, ack;
  logic [6:0] hwAddrPins;
  logic [NUM_LEDS-1:0] ledOut, ledOeN;
  // pulled-up sda, low when either side pulls it
  wire logic sdaWire = sdaDrv & (sdaOeN | sdaOut);
  int failures, comparisons;
  int lowCnt [NUM_LEDS];
  int expLow [NUM_LEDS] = '{2048, 512, 0, 0, 2040, 0, 0, 0};
  // read-back rows: write first when w is set
  lpw_row_t rows [15] = '{
    '{1'b0, 5'h00, 8'h00, 8'h01}, '{1'b0, 5'h01, 8'h00, 8'h06}, '{1'b0, 5'h02, 8'h00, 8'h00},
    '{1'b0, 5'h0a, 8'h00, 8'hff}, '{1'b0, 5'h0e, 8'h00, 8'he2}, '{1'b0, 5'h11, 8'h00, 8'he0},
    '{1'b0, 5'h12, 8'h00, 8'h15}, '{1'b1, 5'h12, 8'hff, 8'h15}, '{1'b1, 5'h13, 8'h55, 8'h00},
    '{1'b1, 5'h03, 8'h40, 8'h40}, '{1'b1, 5'h05, 8'hff, 8'hff}, '{1'b1, 5'h06, 8'hff, 8'hff},
    '{1'b1, 5'h0a, 8'h00, 8'h00}, '{1'b1, 5'h0c, 8'hc9, 8'hc9}, '{1'b1, 5'h0d, 8'h02, 8'h02}};

  lpw_led_pwm #(.BLINK_TICKS(2)) dut_u (.clk(clk), .resetn(resetn), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .sclPin(sclPin), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .hwAddrPins(hwAddrPins),
    .outGateN(outGateN), .ledOut(ledOut), .ledOeN(ledOeN));
  lpw_i2c_master mst_u (.scl(sclPin), .sdaDrv(sdaDrv), .sdaWire(sdaWire));

  // 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // one strobe cycle; read data is taken in the cycle after
  task automatic regAcc(input logic w, input logic [AW-1:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= w;
    regRdStb <= !w;
    @(posedge clk);
    regWrStb <= 1'b0;
    regRdStb <= 1'b0;
    #1 rd = regRdData;
  endtask
  // low cycles over n clocks; 2048 is one pwm period, 4096 one blink period with freq 0
  task automatic pwmCount(input int n);
    lowCnt = '{default: 0};
    repeat (n)
    begin
      @(posedge clk);
      #1;
      foreach (lowCnt[i])
        if (ledOut[i] === 1'b0)
          lowCnt[i]++;
    end
  endtask
  task automatic settle();
    repeat (10) @(posedge clk);
    #1;
  endtask
  task automatic close_out();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // watchdog, run needs about 50 us
  initial
  begin
    #200_000;
    failures++;
    $display("[ERR] %0t watchdog expired", $time);
    close_out();
  end

  initial
  begin
    resetn = 1'b0;
    regAddr = '0;
    regWrData = 8'h00;
    regWrStb = 1'b0;
    regRdStb = 1'b0;
    outGateN = 1'b0;
    hwAddrPins = 7'h15;
    // two cycles of reset; synchronisers start at the idle pin levels
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    #1 chk({ledOut, ledOeN}, 16'hff00, "leds in reset");
    @(posedge clk);
    #1 chk({ledOut, ledOeN}, 16'hff00, "leds after release");
    foreach (rows[i])
    begin
      if (rows[i].w)
        regAcc(1'b1, rows[i].a, rows[i].d);
      regAcc(1'b0, rows[i].a, 8'h00);
      chk(rd, rows[i].e, "register read");
    end
    $display("test registers done");
    pwmCount(2048);
    foreach (lowCnt[i])
      chk(16'(lowCnt[i]), 16'(expLow[i]), "led duty");
    $display("test duty done");
    regAcc(1'b1, REG_MODE_B, 8'h02);
    settle();
    chk({ledOut, 6'h00, ledOeN[2], ledOeN[0]}, 16'h0002, "open drain");
    regAcc(1'b1, REG_MODE_B, 8'h06);
    @(posedge clk) outGateN <= 1'b1;
    settle();
    chk(ledOeN, 8'hff, "gate high-z");
    regAcc(1'b1, REG_MODE_B, 8'h05);
    settle();
    chk({ledOut, ledOeN}, 16'hff00, "gate one");
    regAcc(1'b1, REG_MODE_B, 8'h04);
    settle();
    chk({ledOut, ledOeN}, 16'h0000, "gate zero");
    @(posedge clk) outGateN <= 1'b0;
    regAcc(1'b1, REG_MODE_B, 8'h06);
    $display("test outputs done");
    mst_u.sendAddr(7'h15, 1'b0, ack);
    chk(ack, 1, "own address");
    mst_u.wrByte(8'h02, ack);
    mst_u.wrByte(8'h33, ack);
    chk(ack, 1, "data ack");
    regAcc(1'b0, REG_BRIGHT0, 8'h00);
    chk(rd, 8'h00, "held until stop");
    mst_u.stop();
    settle();
    regAcc(1'b0, REG_BRIGHT0, 8'h00);
    chk(rd, 8'h33, "applied at stop");
    mst_u.sendAddr(7'h15, 1'b1, ack);
    mst_u.rdByte(1'b1, lnk);
    chk(lnk, 8'h40, "link read");
    mst_u.stop();
    mst_u.sendAddr(7'h70, 1'b0, ack);
    chk(ack, 1, "all-call");
    mst_u.stop();
    mst_u.sendAddr(7'h71, 1'b0, ack);
    chk(ack, 0, "sub-call off");
    mst_u.stop();
    mst_u.sendAddr(7'h16, 1'b0, ack);
    chk(ack, 0, "other address");
    mst_u.stop();
    // update on acknowledge: the byte lands before any stop
    regAcc(1'b1, REG_MODE_B, 8'h0e);
    mst_u.sendAddr(7'h15, 1'b0, ack);
    mst_u.wrByte(8'h02, ack);
    mst_u.wrByte(8'h5a, ack);
    regAcc(1'b0, REG_BRIGHT0, 8'h00);
    chk(rd, 8'h5a, "applied at ack");
    mst_u.stop();
    $display("test link done");
    mst_u.sendAddr(7'h03, 1'b1, ack);
    chk(ack, 0, "reset call read");
    mst_u.stop();
    mst_u.sendAddr(7'h03, 1'b0, ack);
    chk(ack, 1, "reset call write");
    mst_u.stop();
    settle();
    chk({ledOut, ledOeN}, 16'hff00, "leds after soft reset");
    regAcc(1'b0, REG_BRIGHT0, 8'h00);
    chk(rd, 8'h00, "reg after soft reset");
    $display("test soft reset done");
    // led0 individual at zero, led1 individual full and group blinking at half duty
    regAcc(1'b1, REG_STATE0, 8'h0e);
    regAcc(1'b1, REG_BRIGHT0 + 5'h01, 8'hff);
    regAcc(1'b1, REG_GRP_DUTY, 8'h80);
    regAcc(1'b1, REG_MODE_B, 8'h26);
    settle();
    pwmCount(4096);
    chk(16'(lowCnt[0]), 16'h0000, "zero brightness");
    chk(16'(lowCnt[1]), 16'h07f8, "blink group gating");
    $display("test blink done");
    // hard reset in mid-run
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    #1 chk({ledOut, ledOeN}, 16'hff00, "leds in mid-run reset");
    @(posedge clk);
    #1 chk({ledOut, ledOeN}, 16'hff00, "leds after mid-run release");
    regAcc(1'b0, REG_GRP_DUTY, 8'h00);
    chk(rd, 8'hff, "group duty after reset");
    regAcc(1'b0, REG_STATE0, 8'h00);
    chk(rd, 8'h00, "led states after reset");
    $display("test hard reset done");
    close_out();
  end
endmodule // testbench
